// ### rtl/sirq_pkg.sv
// sirq_pkg: constants and carrier types for the six-source interrupt block
// assumes: apb slave with byte addresses, one clock domain (pclk)
package sirq_pkg;

	// register byte addresses on the apb bus
	localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88; // external and timer flags
	localparam logic [7:0] ADDR_SERIAL     = 8'h98; // serial done flags
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8; // global and source enables
	localparam logic [7:0] ADDR_IRQ_PRIO   = 8'hB8; // source priority levels
	localparam logic [7:0] ADDR_TMR2_CTRL  = 8'hC8; // timer-2 flags and enable
	localparam logic [7:0] ADDR_EVT_STATUS = 8'hF0; // sticky events, w1c
	localparam logic [7:0] ADDR_EVT_MASK   = 8'hF4; // event mask
	localparam logic [7:0] ADDR_CORE_STATE = 8'hF8; // in-service view, read only

	// timer control register fields
	localparam int TC_EXT0_EDGE = 0;
	localparam int TC_EXT0_FLAG = 1;
	localparam int TC_EXT1_EDGE = 2;
	localparam int TC_EXT1_FLAG = 3;
	localparam int TC_TMR0_OVF  = 5;
	localparam int TC_TMR1_OVF  = 7;

	// serial register fields
	localparam int SER_TX_DONE = 0;
	localparam int SER_RX_DONE = 1;

	// timer-2 control register fields
	localparam int T2_EXT_ENABLE = 3;
	localparam int T2_EXT_FLAG   = 6;
	localparam int T2_OVF        = 7;

	// enable register: global bit, six source bits below
	localparam int IE_GLOBAL = 7;

	// source indices, also the fixed order within a level
	localparam logic [2:0] SRC_EXT0   = 3'h0;
	localparam logic [2:0] SRC_TMR0   = 3'h1;
	localparam logic [2:0] SRC_EXT1   = 3'h2;
	localparam logic [2:0] SRC_TMR1   = 3'h3;
	localparam logic [2:0] SRC_SERIAL = 3'h4;
	localparam logic [2:0] SRC_TMR2   = 3'h5;
	localparam int         NUM_SRC    = 6;

	// vector = base + step * source index
	localparam logic [15:0] VEC_BASE = 16'h0003;
	localparam logic [15:0] VEC_STEP = 16'h0008;

	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [2:0] RST_PINS = 3'h7; // pins idle high

	// answer of the arbiter
	typedef struct packed {
		logic       valid; // something may be vectored
		logic       level; // 1 = high priority
		logic [2:0] id;    // winning source
	} sirq_pick_t;

	// what the core sees
	typedef struct packed {
		logic        req;    // vector request, held until ack
		logic        level;  // priority of the request
		logic [15:0] vector; // vector address
	} sirq_core_t;

	// vector address of a source
	function automatic logic [15:0] sirq_vector(input logic [2:0] id);
		sirq_vector = VEC_BASE + (VEC_STEP * {13'h0000, id});
	endfunction : sirq_vector

endpackage : sirq_pkg

// ### rtl/sirq_sync.sv
// sirq_sync: two-flop synchroniser for asynchronous pins
// assumes: pins idle high; nothing reads the first stage
`timescale 1ns/10ps
module sirq_sync (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// pins in, synchronised levels out
	input  wire logic [2:0] pin_async,
	output logic      [2:0] pin_sync
);
	// both stages of the synchroniser
	typedef struct packed {
		logic [2:0] meta; // first stage, read only by the second
		logic [2:0] sync; // second stage, the only output
	} sirq_stage_t;

	sirq_stage_t stage_reg;  // registered stages
	sirq_stage_t stage_next; // next stages

	// shift the pins one stage along
	always_comb begin
		stage_next.meta = pin_async;
		stage_next.sync = stage_reg.meta;
	end

	// two stages, reset to the idle level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_reg <= {sirq_pkg::RST_PINS, sirq_pkg::RST_PINS};
		end else begin
			stage_reg <= stage_next;
		end
	end

	// output straight from the second flop
	assign pin_sync = stage_reg.sync;
endmodule : sirq_sync

// ### rtl/sirq_arbiter.sv
// sirq_arbiter: picks the source to vector from pending requests
// assumes: inputs are registered state of the same clock
`timescale 1ns/10ps
module sirq_arbiter (
	// requests and configuration
	input  wire logic [7:0] enable,
	input  wire logic [5:0] prio,
	input  wire logic [5:0] req,
	// routines in service
	input  wire logic       act_hi,
	input  wire logic       act_lo,
	// choice
	output sirq_pkg::sirq_pick_t pick
);
	logic [5:0] pend; // enabled requests
	logic [5:0] hi;   // pending at high level
	logic [5:0] lo;   // pending at low level

	// lowest index wins inside a level
	function automatic logic [2:0] first_set(input logic [5:0] v);
		first_set = 3'h0;
		for (int i = sirq_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = 3'(i);
			end
		end
	endfunction : first_set

	// choice across levels and in-service state
	always_comb begin
		pend = enable[sirq_pkg::IE_GLOBAL] ? (req & enable[5:0]) : 6'h00;
		hi   = pend & prio;
		lo   = pend & ~prio;
		pick = '0;
		if ((|hi) && !act_hi) begin
			pick.valid = 1'b1;
			pick.level = 1'b1;
			pick.id    = first_set(hi);
		end else if ((|lo) && !act_hi && !act_lo) begin
			pick.valid = 1'b1;
			pick.level = 1'b0;
			pick.id    = first_set(lo);
		end
	end
endmodule : sirq_arbiter

// ### rtl/sirq_ctrl.sv
// sirq_ctrl: six-source two-level interrupt controller with apb registers
// assumes: peripheral done/overflow strobes are one-cycle pulses on pclk;
// the core pulses core_ack when it vectors and core_reti on return
// level-mode flags are rewritten from the pin every cycle, so software
// writes to them are lost; edge-mode flags hold until cleared
//
// Contract
// - six sources, two levels, fixed order
// - external inputs: level-low or falling edge
// - external requests come from the flags
// - vectoring clears external flag only edge-mode
// - timer 0/1 requests are overflow flags
// - vectoring clears the timer overflow flag
// - serial request is rx or tx flag
// - timer-2 request is overflow or external
// - third external interrupt shares timer-2 slot
// - enabled falling edge sets timer-2 external flag
// - vector addresses 0003H step eight to 002BH
// - interrupt logic runs on during idle
// - external interrupts end power-down mode; here only ext0 and ext1 wake, the timer-2 external pin does not
// - enable register: global bit7, sources 5..0
// - global enable low blocks every interrupt; the event irq line ignores it
// - priority register bits 5..0, 7..6 reserved
`timescale 1ns/10ps
module sirq_ctrl (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// external pins, asynchronous
	input  wire logic        ext_irq0_pin,
	input  wire logic        ext_irq1_pin,
	input  wire logic        tmr2_external_pin,
	// peripheral strobes, same clock
	input  wire logic        tmr0_overflow,
	input  wire logic        tmr1_overflow,
	input  wire logic        tmr0_split_mode,
	input  wire logic        tmr2_overflow,
	input  wire logic        serial_rx_done,
	input  wire logic        serial_tx_done,
	// processor core
	input  wire logic        core_ack,
	input  wire logic        core_reti,
	input  wire logic        power_down,
	output sirq_pkg::sirq_core_t core_out,
	output logic             wake_up,
	// interrupt line to system
	output logic             irq
);
	// all state of the block
	typedef struct packed {
		logic [7:0]  timer_control_reg;  // external and timer flags
		logic [1:0]  serial_reg;         // rx and tx done
		logic [7:0]  irq_enable_reg;     // enables
		logic [5:0]  irq_priority_reg;   // levels
		logic [7:0]  tmr2_control_reg;   // timer-2 flags and enable
		logic [5:0]  evt_status;         // sticky events
		logic [5:0]  evt_mask;           // event mask
		logic [5:0]  req_prev;           // request lines last cycle
		logic [2:0]  pins_prev;          // synced pins last cycle
		logic        act_hi;             // high routine in service
		logic        act_lo;             // low routine in service
		logic [2:0]  src;                // source of pending request
		sirq_pkg::sirq_core_t core;      // request to core
		logic        wake;               // power-down exit
		logic        irq;                // interrupt line
		logic [31:0] rdata;              // apb read data
		logic        ready;              // apb ready
		logic        err;                // apb error
	} sirq_state_t;

	sirq_state_t          state_reg;  // registered state
	sirq_state_t          state_next; // next state
	logic [2:0]           pins;       // synced ext0, ext1, tmr2 pins
	logic [5:0]           req;        // six request lines
	sirq_pkg::sirq_pick_t pick;       // arbiter choice
	logic                 wr;         // apb write in access phase
	logic [2:0]           fall;       // falling edges of pins

	// pins cross into pclk before anyone looks at them
	sirq_sync u_sync (
		.pclk      (pclk),
		.presetn   (presetn),
		.pin_async ({tmr2_external_pin, ext_irq1_pin, ext_irq0_pin}),
		.pin_sync  (pins)
	);

	// request lines in the fixed source order
	always_comb begin
		req[sirq_pkg::SRC_EXT0] =
			state_reg.timer_control_reg[sirq_pkg::TC_EXT0_FLAG];
		req[sirq_pkg::SRC_TMR0] =
			state_reg.timer_control_reg[sirq_pkg::TC_TMR0_OVF];
		// external 1 flag
		req[sirq_pkg::SRC_EXT1] =
			state_reg.timer_control_reg[sirq_pkg::TC_EXT1_FLAG];
		// timer 1 overflow flag
		req[sirq_pkg::SRC_TMR1] =
			state_reg.timer_control_reg[sirq_pkg::TC_TMR1_OVF];
		req[sirq_pkg::SRC_SERIAL] = |state_reg.serial_reg;
		req[sirq_pkg::SRC_TMR2] =
			state_reg.tmr2_control_reg[sirq_pkg::T2_OVF] |
			state_reg.tmr2_control_reg[sirq_pkg::T2_EXT_FLAG];
	end

	// priority choice; it never looks at power or idle state
	// the arbiter keeps no state of its own
	sirq_arbiter u_arb (
		.enable (state_reg.irq_enable_reg),
		.prio   (state_reg.irq_priority_reg),
		.req    (req),
		.act_hi (state_reg.act_hi),
		.act_lo (state_reg.act_lo),
		.pick   (pick)
	);

	// write lands at the access edge, the one at which pready is high
	assign wr   = psel & penable & pwrite & state_reg.ready;
	// one-cycle falling edge of each synced pin
	assign fall = state_reg.pins_prev & ~pins;

	// next state: software first, hardware clears, hardware sets last
	always_comb begin
		state_next           = state_reg;
		state_next.pins_prev = pins;
		state_next.req_prev  = req;

		// register writes
		if (wr) begin
			case (paddr)
				// flag bits lose to hardware sets below
				sirq_pkg::ADDR_TIMER_CTRL: begin
					state_next.timer_control_reg = pwdata[7:0];
				end
				// only software clears serial flags
				sirq_pkg::ADDR_SERIAL: begin
					state_next.serial_reg = pwdata[1:0];
				end
				sirq_pkg::ADDR_IRQ_ENABLE: begin
					state_next.irq_enable_reg = {pwdata[7], 1'b0, pwdata[5:0]};
				end
				sirq_pkg::ADDR_IRQ_PRIO: begin
					state_next.irq_priority_reg = pwdata[5:0];
				end
				// only software clears timer-2 flags
				sirq_pkg::ADDR_TMR2_CTRL: begin
					state_next.tmr2_control_reg = pwdata[7:0];
				end
				// write one to clear
				sirq_pkg::ADDR_EVT_STATUS: begin
					state_next.evt_status = state_reg.evt_status & ~pwdata[5:0];
				end
				sirq_pkg::ADDR_EVT_MASK: begin
					state_next.evt_mask = pwdata[5:0];
				end
				default: begin
					// read-only or unmapped: nothing stored
				end
			endcase
		end

		// core takes the pending vector
		// an ack with no request standing is ignored
		if (core_ack && state_reg.core.req) begin
			// the level of the taken request goes in service
			if (state_reg.core.level) begin
				state_next.act_hi = 1'b1;
			end else begin
				state_next.act_lo = 1'b1;
			end
			case (state_reg.src)
				sirq_pkg::SRC_EXT0: begin
					if (state_reg.timer_control_reg[sirq_pkg::TC_EXT0_EDGE]) begin
						state_next.timer_control_reg[sirq_pkg::TC_EXT0_FLAG] = 1'b0;
					end
				end
				sirq_pkg::SRC_EXT1: begin
					if (state_reg.timer_control_reg[sirq_pkg::TC_EXT1_EDGE]) begin
						state_next.timer_control_reg[sirq_pkg::TC_EXT1_FLAG] = 1'b0;
					end
				end
				sirq_pkg::SRC_TMR0: begin
					state_next.timer_control_reg[sirq_pkg::TC_TMR0_OVF] = 1'b0;
				end
				sirq_pkg::SRC_TMR1: begin
					state_next.timer_control_reg[sirq_pkg::TC_TMR1_OVF] = 1'b0;
				end
				// serial and timer-2 flags are left for software
				default: begin
				end
			endcase
		end

		// return ends the highest level in service
		if (core_reti) begin
			// a return with nothing in service changes nothing
			if (state_reg.act_hi) begin
				state_next.act_hi = 1'b0;
			end else begin
				state_next.act_lo = 1'b0;
			end
		end

		if (state_reg.timer_control_reg[sirq_pkg::TC_EXT0_EDGE]) begin
			if (fall[0]) begin
				state_next.timer_control_reg[sirq_pkg::TC_EXT0_FLAG] = 1'b1;
			end
		end else begin
			state_next.timer_control_reg[sirq_pkg::TC_EXT0_FLAG] = ~pins[0];
		end
		// external 1, same two modes
		if (state_reg.timer_control_reg[sirq_pkg::TC_EXT1_EDGE]) begin
			if (fall[1]) begin
				state_next.timer_control_reg[sirq_pkg::TC_EXT1_FLAG] = 1'b1;
			end
		end else begin
			state_next.timer_control_reg[sirq_pkg::TC_EXT1_FLAG] = ~pins[1];
		end

		if (tmr0_overflow) begin
			state_next.timer_control_reg[sirq_pkg::TC_TMR0_OVF] = 1'b1;
		end
		// timer 1 cannot flag while timer 0 runs split
		if (tmr1_overflow && !tmr0_split_mode) begin
			state_next.timer_control_reg[sirq_pkg::TC_TMR1_OVF] = 1'b1;
		end
		// serial done flags; vectoring never clears them
		if (serial_rx_done) begin
			state_next.serial_reg[sirq_pkg::SER_RX_DONE] = 1'b1;
		end
		if (serial_tx_done) begin
			state_next.serial_reg[sirq_pkg::SER_TX_DONE] = 1'b1;
		end
		// timer-2 overflow, cleared by software only
		if (tmr2_overflow) begin
			state_next.tmr2_control_reg[sirq_pkg::T2_OVF] = 1'b1;
		end
		if (fall[2] &&
			state_reg.tmr2_control_reg[sirq_pkg::T2_EXT_ENABLE]) begin
			state_next.tmr2_control_reg[sirq_pkg::T2_EXT_FLAG] = 1'b1;
		end

		// new requests set sticky events; set beats a clear
		state_next.evt_status = state_next.evt_status |
			(req & ~state_reg.req_prev);
		// irq from the next state, so the line itself is a flop
		state_next.irq = |(state_next.evt_status & state_next.evt_mask);

		// runs regardless of idle
		// req falls after an ack so one vector is taken once
		state_next.core.req    = pick.valid & ~core_ack;
		state_next.core.level  = pick.level;
		state_next.core.vector = sirq_pkg::sirq_vector(pick.id);
		state_next.src         = pick.id;

		// either external wakes
		// gated like a request: a disabled pin cannot wake
		state_next.wake = power_down &
			state_reg.irq_enable_reg[sirq_pkg::IE_GLOBAL] &
			((req[sirq_pkg::SRC_EXT0] &
			  state_reg.irq_enable_reg[sirq_pkg::SRC_EXT0]) |
			 (req[sirq_pkg::SRC_EXT1] &
			  state_reg.irq_enable_reg[sirq_pkg::SRC_EXT1]));

		// apb: data captured in setup, ready in access
		// zero wait states: ready stands only in the access cycle
		state_next.ready = psel & ~penable;
		state_next.err   = 1'b0;
		state_next.rdata = 32'h0000_0000;
		if (psel && !penable) begin
			case (paddr)
				sirq_pkg::ADDR_TIMER_CTRL: begin
					state_next.rdata[7:0] = state_reg.timer_control_reg;
				end
				sirq_pkg::ADDR_SERIAL: begin
					state_next.rdata[1:0] = state_reg.serial_reg;
				end
				sirq_pkg::ADDR_IRQ_ENABLE: begin
					state_next.rdata[7:0] = state_reg.irq_enable_reg;
				end
				sirq_pkg::ADDR_IRQ_PRIO: begin
					state_next.rdata[5:0] = state_reg.irq_priority_reg;
				end
				sirq_pkg::ADDR_TMR2_CTRL: begin
					state_next.rdata[7:0] = state_reg.tmr2_control_reg;
				end
				sirq_pkg::ADDR_EVT_STATUS: begin
					state_next.rdata[5:0] = state_reg.evt_status;
				end
				sirq_pkg::ADDR_EVT_MASK: begin
					state_next.rdata[5:0] = state_reg.evt_mask;
				end
				// in-service bits and the presented source
				sirq_pkg::ADDR_CORE_STATE: begin
					state_next.rdata[5:0] = {state_reg.act_hi, state_reg.act_lo,
						state_reg.core.req, state_reg.src};
				end
				// unmapped: error, data zero
				default: begin
					state_next.err = 1'b1;
				end
			endcase
		end
	end

	// one register for the whole state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg           <= '0;
			// pins start idle high, so reset makes no false edge
			state_reg.pins_prev <= sirq_pkg::RST_PINS;
		end else begin
			state_reg <= state_next;
		end
	end

	// outputs straight from the state flops
	assign prdata   = state_reg.rdata;
	assign pready   = state_reg.ready;
	assign pslverr  = state_reg.err;
	assign core_out = state_reg.core;
	assign wake_up  = state_reg.wake;
	assign irq      = state_reg.irq;
endmodule : sirq_ctrl

// ### bench/sirq_ctrl_assertions.sv
// sirq_ctrl_assertions: port-level checks on the interrupt block
// assumes: bound into every sirq_ctrl, one clock domain on pclk
`timescale 1ns/10ps
module sirq_ctrl_assertions (
	// clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// apb handshake
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// core side
	input wire logic                 core_ack,
	input wire logic                 power_down,
	input wire sirq_pkg::sirq_core_t core_out,
	input wire logic                 wake_up,
	input wire logic                 irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ready_after_setup_a:
	assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_one_cycle_a:
	assert property (pready |=> !pready)
		else $error("answer stood too long");
	ready_cause_a:
	assert property ($rose(pready) |-> $past(psel) && !$past(penable))
		else $error("answer without setup");
	err_answer_a:
	assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer malformed");
	req_held_a:
	assert property (core_out.req && !core_ack
		|=> core_out.req && $stable(core_out.vector))
		else $error("request dropped before ack");
	req_drop_a:
	assert property (core_out.req && core_ack |=> !core_out.req)
		else $error("request stood after ack");
	vector_legal_a:
	assert property (core_out.req |-> core_out.vector[2:0] == 3'h3
		&& core_out.vector <= 16'h002B)
		else $error("vector off the table");
	wake_gate_a:
	assert property (!power_down |=> !wake_up)
		else $error("wake outside power-down");

	// main scenarios reached
	cover property (core_out.req && core_ack);
	cover property (wake_up);
	cover property (irq);
	cover property (pslverr);
endmodule : sirq_ctrl_assertions

bind sirq_ctrl sirq_ctrl_assertions sirq_ctrl_assertions_i (.pclk,
	.presetn, .psel, .penable, .prdata, .pready, .pslverr, .core_ack,
	.power_down, .core_out, .wake_up, .irq);

// ### bench/sirq_core_model.sv
// sirq_core_model: behavioural core that vectors and returns
// assumes: core_out registered on pclk; bench calls ret after an edge
`timescale 1ns/10ps
module sirq_core_model (
	// clock and reset
	input wire logic                 pclk,
	input wire logic                 presetn,
	// request in, handshake out
	input wire sirq_pkg::sirq_core_t core_out,
	output logic                     core_ack,
	output logic                     core_reti
);
	int          delay    = 2;       // cycles before vectoring
	int          acks     = 0;       // vectors taken
	int          cnt      = 0;       // wait counter
	logic        stall    = 1'b0;    // holds off vectoring
	logic [15:0] last_vec = 16'h0000; // vector of last ack

	initial begin
		core_ack = 1'b0;
		core_reti = 1'b0;
	end

	// ack a standing request late, never twice for one request
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_ack <= 1'b0;
			cnt <= 0;
		end else if (core_out.req && !core_ack && !stall && cnt >= delay) begin
			core_ack <= 1'b1;
			last_vec <= core_out.vector;
			acks <= acks + 1;
			cnt <= 0;
		end else begin
			core_ack <= 1'b0;
			cnt <= core_out.req ? cnt + 1 : 0;
		end
	end

	task automatic ret();
		core_reti <= 1'b1;
		@(posedge pclk);
		core_reti <= 1'b0;
		@(posedge pclk);
	endtask : ret
endmodule : sirq_core_model

// ### bench/test_sirq_ctrl.sv
// test_sirq_ctrl: directed bench for the six-source interrupt block
// assumes: apb slave answers in its own time; core model answers vectors
`timescale 1ns/10ps
`define CHK(n, x, y) begin check_count++; if ((x) !== (y)) begin \
	miscompares++; $display("wrong value %s exp %0h got %0h", n, y, x); \
	end end
module test_sirq_ctrl;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, wake_up, irq, core_ack, core_reti;
	logic [2:0]  pins = 3'h7;   // {tmr2 ext, ext1, ext0}, idle high
	logic [4:0]  stb = 5'h00;   // {tmr2, tx, rx, tmr1, tmr0}
	logic        split = 1'b0, power_down = 1'b0;
	sirq_pkg::sirq_core_t core_out;
	int          miscompares = 0, check_count = 0, na = 0;
	logic [15:0] vecs [6] = '{16'h002B, 16'h0003, 16'h000B,
		16'h0013, 16'h001B, 16'h0023};

	always #25 pclk = ~pclk;

	sirq_ctrl sirq_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.ext_irq0_pin(pins[0]), .ext_irq1_pin(pins[1]),
		.tmr2_external_pin(pins[2]), .tmr0_overflow(stb[0]),
		.tmr1_overflow(stb[1]), .tmr0_split_mode(split),
		.tmr2_overflow(stb[4]), .serial_rx_done(stb[2]),
		.serial_tx_done(stb[3]), .core_ack, .core_reti, .power_down,
		.core_out, .wake_up, .irq);
	sirq_core_model sirq_core_model_i (.pclk, .presetn, .core_out,
		.core_ack, .core_reti);

	// one apb transfer, waits for pready; q = {pslverr, prdata}
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [32:0] q);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [32:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic e = 1'b0);
		logic [32:0] q;
		apb(1'b0, a, 32'h0, q);
		`CHK($sformatf("reg %h", a), q, {e, x})
	endtask : rd

	// one-cycle peripheral strobes
	task automatic strobe(input logic [4:0] m);
		stb <= m;
		@(posedge pclk);
		stb <= 5'h00;
		@(posedge pclk);
	endtask : strobe

	// wait for the next vector and compare it
	task automatic take(input logic [15:0] v);
		int k = 0;
		na++;
		while (sirq_core_model_i.acks < na && k < 200) begin
			@(posedge pclk);
			k++;
		end
		`CHK("acks", sirq_core_model_i.acks, na)
		`CHK("vector", sirq_core_model_i.last_vec, v)
	endtask : take

	// routine: software clears the flags hardware leaves alone
	task automatic serve(input logic [15:0] v, input logic [31:0] t2);
		take(v);
		if (v == 16'h0023) begin
			rd(8'h98, 32'h3);
			wr(8'h98, 32'h0);
		end
		if (v == 16'h002B) begin
			rd(8'hC8, t2);
			wr(8'hC8, 32'h08);
		end
		sirq_core_model_i.ret();
	endtask : serve

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	// watchdog at 20000 cycles, far beyond the few hundred needed
	initial begin
		#(50 * 20000);
		miscompares++;
		end_of_test();
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'hA8, 32'h0);
		rd(8'hB8, 32'h0);
		rd(8'h10, 32'h0, 1'b1);
		$display("test reset done");
		// all sources at once, timer-2 at high level
		wr(8'hA8, 32'hBF);
		wr(8'hB8, 32'h20);
		wr(8'h88, 32'h05);
		wr(8'hC8, 32'h08);
		pins <= 3'h0;
		strobe(5'h1F);
		pins <= 3'h7;
		foreach (vecs[i]) serve(vecs[i], 32'hC8);
		rd(8'h88, 32'h05);
		$display("test order done");
		// equal level waits, high preempts low
		strobe(5'h01);
		take(16'h000B);
		strobe(5'h02);
		repeat (8) @(posedge pclk);
		`CHK("acks", sirq_core_model_i.acks, na)
		strobe(5'h10);
		serve(16'h002B, 32'h88);
		repeat (8) @(posedge pclk);
		`CHK("acks", sirq_core_model_i.acks, na)
		sirq_core_model_i.ret();
		serve(16'h001B, 32'h0);
		$display("test preempt done");
		// global off, events, split mode
		wr(8'hF0, 32'h3F);
		wr(8'hA8, 32'h02);
		strobe(5'h01);
		repeat (6) @(posedge pclk);
		`CHK("acks", sirq_core_model_i.acks, na)
		`CHK("irq", irq, 1'b0)
		rd(8'hF0, 32'h02);
		wr(8'hF4, 32'h02);
		repeat (2) @(posedge pclk);
		`CHK("irq", irq, 1'b1)
		wr(8'hF0, 32'h02);
		repeat (2) @(posedge pclk);
		`CHK("irq", irq, 1'b0)
		split <= 1'b1;
		strobe(5'h02);
		split <= 1'b0;
		rd(8'h88, 32'h25);
		wr(8'hA8, 32'h82);
		serve(16'h000B, 32'h0);
		$display("test events done");
		// level mode: flag follows pin, vectoring leaves it set
		wr(8'h88, 32'h01);
		wr(8'hC8, 32'h00);
		wr(8'hA8, 32'h84);
		pins <= 3'h1;
		take(16'h0013);
		rd(8'h88, 32'h09);
		rd(8'hC8, 32'h00);
		pins <= 3'h7;
		repeat (4) @(posedge pclk);
		rd(8'h88, 32'h01);
		sirq_core_model_i.ret();
		$display("test level done");
		// external edge wakes from power-down
		sirq_core_model_i.stall <= 1'b1;
		wr(8'hA8, 32'h81);
		power_down <= 1'b1;
		pins <= 3'h6;
		repeat (6) @(posedge pclk);
		`CHK("wake_up", wake_up, 1'b1)
		pins <= 3'h7;
		power_down <= 1'b0;
		sirq_core_model_i.stall <= 1'b0;
		serve(16'h0003, 32'h0);
		$display("test wake done");
		end_of_test();
	end
endmodule : test_sirq_ctrl
